// file: pbm_defs.svh
// Constants of the port B to E function multiplexer.
// Assumes inclusion by bare name.
`ifndef PBM_DEFS_SVH
`define PBM_DEFS_SVH

`define PBM_PORT_W 8
`define PBM_MODE_W 3
`define PBM_MODE_LO 1:0
`define PBM_MODE_DE_BIT 2
`define PBM_DED_W 2
`define PBM_SYN_W 34
`define PBM_SYN_PB 7:0
`define PBM_SYN_PC 15:8
`define PBM_SYN_PD 23:16
`define PBM_SYN_PE 31:24
`define PBM_SYN_DED 33:32
`define PBM_ZERO_BYTE 8'h00
`define PBM_ZERO_MODE 3'h0
`define PBM_IRQ_W 5
`define PBM_IRQ_ZERO 0
`define PBM_IRQ_ONE 1
`define PBM_IRQ_FOUR 2
`define PBM_IRQ_FIVE 3
`define PBM_IRQ_SIX 4
`define PBM_B_T2IN 0
`define PBM_B_T2EX 1
`define PBM_B_RX1 2
`define PBM_B_TX1 3
`define PBM_B_EXT_IRQ_FOUR 4
`define PBM_B_EXT_IRQ_FIVE_N 5
`define PBM_B_EXT_IRQ_SIX 6
`define PBM_B_TIMER2_OVERFLOW_PULSE 7
`define PBM_C_RX0 0
`define PBM_C_TX0 1
`define PBM_C_EXT_IRQ_ZERO_N 2
`define PBM_C_EXT_IRQ_ONE_N 3
`define PBM_C_T0 4
`define PBM_C_T1 5
`define PBM_C_WR 6
`define PBM_C_RD 7
`define PBM_E_ADDR_TOP 4
`define PBM_E_WAVE_CONTROL_3 5
`define PBM_E_WAVE_CONTROL_5 7
`define PBM_DED_0 0
`define PBM_DED_1 1

`endif

// file: pbm_pkg.sv
// Types shared by the port function multiplexer modules.
// Assumes the low mode bits decode through this enum.
package pbm_pkg;
    typedef enum logic [1:0] {
        PBM_MODE_PORTS,
        PBM_MODE_CPU_BUS,
        PBM_MODE_WAVE,
        PBM_MODE_FIFO
    } pbm_mode_e;
    typedef logic [1:0] pbm_drive_t;
endpackage : pbm_pkg

// file: pbm_sync_if.sv
// Raw pin levels in, synchronised levels out.
// Assumes one clock domain on both sides.
`timescale 1ns/1ps
interface pbm_sync_if #(
    parameter int W = 1
);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport src (output raw, input sync);
    modport syncer (input raw, output sync);
endinterface : pbm_sync_if

// file: pbm_sync.sv
// Two flip-flop synchroniser bank for pin inputs.
// Assumes raw levels come from pins.
`timescale 1ns/1ps
`include "pbm_defs.svh"
module pbm_sync #(
    parameter int W = `PBM_SYN_W
) (
    input wire logic i_clk,
    input wire logic i_rst,
    pbm_sync_if.syncer bus
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    initial begin
        if (W < 1) begin
            $error("Width below one.");
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= bus.raw;
            sync_q <= meta_q;
        end
    end

    assign bus.sync = sync_q;
endmodule : pbm_sync

// file: pbm_irq_edge.sv
// Edge or level request detectors, one per lane.
// Assumes synchronised levels and a per-lane enable.
`timescale 1ns/1ps
module pbm_irq_edge #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_level,
    input wire logic [W-1:0] i_enable,
    input wire logic [W-1:0] i_falling,
    input wire logic [W-1:0] i_edge_mode,
    output logic [W-1:0] o_req
);
    logic [W-1:0] active;
    logic [W-1:0] prev_q;
    logic [W-1:0] req_q;

    initial begin
        if (W < 1) begin
            $error("Width below one.");
        end
    end

    assign active = i_enable & (i_level ^ i_falling);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_q <= '0;
        end else begin
            prev_q <= active;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            req_q <= '0;
        end else begin
            req_q <= (i_edge_mode & active & ~prev_q) | (~i_edge_mode & active);
        end
    end

    assign o_req = req_q;
endmodule : pbm_irq_edge

// file: pbm_port_mux.sv
// Pin function mux for ports B to E and two dedicated inputs.
// Assumes all sources run on I_REF_CLK; pins pass two flip-flops first.
// What this block does
// - Port B: GPIO, peripheral, bus, wave, FIFO.
// - Reset makes every pin an input.
// - B3 drives UART1 transmit.
// - B4 rising edge requests IRQ4.
// - B5 falling edge requests IRQ5.
// - B6 rising edge requests IRQ6.
// - B7 pulses on timer2 overflow.
// - Port C: GPIO, peripheral or wave.
// - IRQ0/IRQ1 edge or level per trigger bit.
// - Timer0/1 count pins used only in counter mode.
// - C6, C7 carry memory strobes or controls.
// - C0, C1 carry UART0 or ready.
// - Port D: GPIO, wave data B, FIFO B.
// - Port E 0-4 carry wave address; bit5 dedicated.
// - FIFO mode puts five flags on port E.
// - Port E bits 5-7 carry wave controls 3-5.
// - Dedicated pins feed ready or FIFO selects.
`timescale 1ns/1ps
`include "pbm_defs.svh"
module pbm_port_mux (
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic [`PBM_MODE_W-1:0] I_INTERFACE_MODE_FIELD,
    input wire logic [`PBM_PORT_W-1:0] I_PORT_B_ALT_SELECT,
    input wire logic [`PBM_PORT_W-1:0] I_PORT_C_ALT_SELECT,
    input wire logic [`PBM_PORT_W-1:0] I_PORT_C_WAVE_SELECT,
    input wire logic I_IRQ_ZERO_TRIGGER_TYPE,
    input wire logic I_IRQ_ONE_TRIGGER_TYPE,
    input wire logic I_TIMER0_COUNTER_MODE,
    input wire logic I_TIMER1_COUNTER_MODE,
    input wire logic [`PBM_PORT_W-1:0] I_PB_PIN,
    output logic [`PBM_PORT_W-1:0] O_PB_PIN,
    output logic [`PBM_PORT_W-1:0] O_PB_PIN_OE,
    input wire logic [`PBM_PORT_W-1:0] I_PC_PIN,
    output logic [`PBM_PORT_W-1:0] O_PC_PIN,
    output logic [`PBM_PORT_W-1:0] O_PC_PIN_OE,
    input wire logic [`PBM_PORT_W-1:0] I_PD_PIN,
    output logic [`PBM_PORT_W-1:0] O_PD_PIN,
    output logic [`PBM_PORT_W-1:0] O_PD_PIN_OE,
    input wire logic [`PBM_PORT_W-1:0] I_PE_PIN,
    output logic [`PBM_PORT_W-1:0] O_PE_PIN,
    output logic [`PBM_PORT_W-1:0] O_PE_PIN_OE,
    input wire logic [`PBM_DED_W-1:0] I_DED_PIN,
    output logic O_WAVE_ADDRESS_5,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_B_OUT,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_B_OE,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_C_OUT,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_C_OE,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_D_OUT,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_D_OE,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_E_OUT,
    input wire logic [`PBM_PORT_W-1:0] I_GPIO_E_OE,
    output logic [`PBM_PORT_W-1:0] O_PORT_B_LEVEL,
    output logic [`PBM_PORT_W-1:0] O_PORT_C_LEVEL,
    output logic [`PBM_PORT_W-1:0] O_PORT_D_LEVEL,
    output logic [`PBM_PORT_W-1:0] O_PORT_E_LEVEL,
    input wire logic [`PBM_PORT_W-1:0] I_CPU_DATA_OUT,
    input wire logic I_CPU_DATA_OE,
    input wire logic [`PBM_PORT_W-1:0] I_WAVE_DATA_A_OUT,
    input wire logic I_WAVE_DATA_A_OE,
    input wire logic [`PBM_PORT_W-1:0] I_WAVE_DATA_B_OUT,
    input wire logic I_WAVE_DATA_B_OE,
    input wire logic [`PBM_PORT_W-3:0] I_WAVE_ADDRESS,
    input wire logic I_WAVE_CONTROL_1,
    input wire logic I_WAVE_CONTROL_3,
    input wire logic I_WAVE_CONTROL_4,
    input wire logic I_WAVE_CONTROL_5,
    output logic O_WAVE_READY_0,
    output logic O_WAVE_READY_1,
    output logic O_WAVE_READY_3,
    input wire logic [`PBM_PORT_W-1:0] I_FIFO_A_DATA_OUT,
    input wire logic I_FIFO_A_DATA_OE,
    input wire logic [`PBM_PORT_W-1:0] I_FIFO_B_DATA_OUT,
    input wire logic I_FIFO_B_DATA_OE,
    input wire logic I_FIFO_B_OUT_LEVEL_FLAG,
    input wire logic I_FIFO_A_IN_FULL,
    input wire logic I_FIFO_B_IN_FULL,
    input wire logic I_FIFO_A_OUT_EMPTY,
    input wire logic I_FIFO_B_OUT_EMPTY,
    output logic O_FIFO_A_SELECT,
    output logic O_FIFO_B_SELECT,
    input wire logic I_UART1_TRANSMIT,
    input wire logic I_UART0_TRANSMIT,
    input wire logic I_TIMER2_OVERFLOW_PULSE,
    input wire logic I_MEM_WRITE_N,
    input wire logic I_MEM_READ_N,
    output logic O_TIMER2_COUNT_INPUT,
    output logic O_TIMER2_RELOAD_INPUT,
    output logic O_UART1_RECEIVE,
    output logic O_UART0_RECEIVE,
    output logic O_TIMER0_COUNT_INPUT,
    output logic O_TIMER1_COUNT_INPUT,
    output logic O_IRQ_ZERO_REQ,
    output logic O_IRQ_ONE_REQ,
    output logic O_IRQ_FOUR_REQ,
    output logic O_IRQ_FIVE_REQ,
    output logic O_IRQ_SIX_REQ
);
    logic [`PBM_MODE_W-1:0] mode_q;
    logic [`PBM_PORT_W-1:0] b_alt_q, c_alt_q, c_wave_q;
    pbm_pkg::pbm_mode_e mode;
    logic de_on;
    logic [`PBM_PORT_W-1:0] b_per, c_per, c_wav, pb_s, pc_s;
    logic [`PBM_DED_W-1:0] ded_s;
    logic [`PBM_PORT_W-1:0] pb_d, pb_oe_d, pc_d, pc_oe_d, pd_d, pd_oe_d;
    logic [`PBM_PORT_W-1:0] pe_d, pe_oe_d, pb_q, pb_oe_q, pc_q, pc_oe_q;
    logic [`PBM_PORT_W-1:0] pd_q, pd_oe_q, pe_q, pe_oe_q;
    logic addr5_q;
    logic [`PBM_IRQ_W-1:0] irq_lvl, irq_en, irq_fall, irq_edge, irq_req;

    pbm_sync_if #(.W(`PBM_SYN_W)) syn ();
    // Picks the alternate or the GPIO drive.
    function automatic pbm_pkg::pbm_drive_t route(input logic sel,
        input logic alt_out, input logic alt_oe, input logic gpio_out,
        input logic gpio_oe);
        route = sel ? {alt_oe, alt_out} : {gpio_oe, gpio_out};
    endfunction : route

    // Reset config selects port mode with every pin on its GPIO drive.
    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            mode_q <= `PBM_ZERO_MODE;
            b_alt_q <= `PBM_ZERO_BYTE;
            c_alt_q <= `PBM_ZERO_BYTE;
            c_wave_q <= `PBM_ZERO_BYTE;
        end else begin
            mode_q <= I_INTERFACE_MODE_FIELD;
            b_alt_q <= I_PORT_B_ALT_SELECT;
            c_alt_q <= I_PORT_C_ALT_SELECT;
            c_wave_q <= I_PORT_C_WAVE_SELECT;
        end
    end

    assign mode = pbm_pkg::pbm_mode_e'(mode_q[`PBM_MODE_LO]);
    assign de_on = mode_q[`PBM_MODE_DE_BIT];
    assign b_per = (mode == pbm_pkg::PBM_MODE_PORTS) ? b_alt_q : '0;
    assign c_per = c_alt_q & ~c_wave_q;
    assign c_wav = c_alt_q & c_wave_q & ~(8'h01 << `PBM_C_EXT_IRQ_ZERO_N);

    assign syn.raw = {I_DED_PIN, I_PE_PIN, I_PD_PIN, I_PC_PIN, I_PB_PIN};

    pbm_sync #(.W(`PBM_SYN_W)) u_sync (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .bus(syn)
    );

    assign pb_s = syn.sync[`PBM_SYN_PB];
    assign pc_s = syn.sync[`PBM_SYN_PC];
    assign ded_s = syn.sync[`PBM_SYN_DED];
    // Pin levels stay readable.
    assign O_PORT_B_LEVEL = pb_s;
    assign O_PORT_C_LEVEL = pc_s;
    assign O_PORT_D_LEVEL = syn.sync[`PBM_SYN_PD];
    assign O_PORT_E_LEVEL = syn.sync[`PBM_SYN_PE];

    always_comb begin
        pb_d = '0;
        pb_oe_d = '0;
        for (int i = 0; i < `PBM_PORT_W; i++) begin
            unique case (mode)
                pbm_pkg::PBM_MODE_PORTS: begin
                    {pb_oe_d[i], pb_d[i]} = route(b_alt_q[i], 1'b0, 1'b0,
                        I_GPIO_B_OUT[i], I_GPIO_B_OE[i]);
                end
                pbm_pkg::PBM_MODE_CPU_BUS: begin
                    {pb_oe_d[i], pb_d[i]} = {I_CPU_DATA_OE, I_CPU_DATA_OUT[i]};
                end
                pbm_pkg::PBM_MODE_WAVE: begin
                    {pb_oe_d[i], pb_d[i]} = {I_WAVE_DATA_A_OE,
                        I_WAVE_DATA_A_OUT[i]};
                end
                pbm_pkg::PBM_MODE_FIFO: begin
                    {pb_oe_d[i], pb_d[i]} = {I_FIFO_A_DATA_OE,
                        I_FIFO_A_DATA_OUT[i]};
                end
            endcase
        end
        if (b_per[`PBM_B_TX1]) begin
            {pb_oe_d[`PBM_B_TX1], pb_d[`PBM_B_TX1]} =
                {1'b1, I_UART1_TRANSMIT};
        end
        if (b_per[`PBM_B_TIMER2_OVERFLOW_PULSE]) begin
            {pb_oe_d[`PBM_B_TIMER2_OVERFLOW_PULSE], pb_d[`PBM_B_TIMER2_OVERFLOW_PULSE]} =
                {1'b1, I_TIMER2_OVERFLOW_PULSE};
        end
    end

    always_comb begin
        for (int i = 0; i < `PBM_PORT_W; i++) begin
            {pc_oe_d[i], pc_d[i]} = route(c_alt_q[i], 1'b0, 1'b0,
                I_GPIO_C_OUT[i], I_GPIO_C_OE[i]);
        end
        if (c_per[`PBM_C_TX0]) begin
            {pc_oe_d[`PBM_C_TX0], pc_d[`PBM_C_TX0]} =
                {1'b1, I_UART0_TRANSMIT};
        end
        if (c_wav[`PBM_C_T0]) begin
            {pc_oe_d[`PBM_C_T0], pc_d[`PBM_C_T0]} = {1'b1, I_WAVE_CONTROL_1};
        end
        if (c_wav[`PBM_C_T1]) begin
            {pc_oe_d[`PBM_C_T1], pc_d[`PBM_C_T1]} = {1'b1, I_WAVE_CONTROL_3};
        end
        if (c_alt_q[`PBM_C_WR]) begin
            {pc_oe_d[`PBM_C_WR], pc_d[`PBM_C_WR]} = {1'b1,
                c_wave_q[`PBM_C_WR] ? I_WAVE_CONTROL_4 : I_MEM_WRITE_N};
        end
        if (c_alt_q[`PBM_C_RD]) begin
            {pc_oe_d[`PBM_C_RD], pc_d[`PBM_C_RD]} = {1'b1,
                c_wave_q[`PBM_C_RD] ? I_WAVE_CONTROL_5 : I_MEM_READ_N};
        end
    end

    always_comb begin
        for (int i = 0; i < `PBM_PORT_W; i++) begin
            {pd_oe_d[i], pd_d[i]} = {I_GPIO_D_OE[i], I_GPIO_D_OUT[i]};
            {pe_oe_d[i], pe_d[i]} = {I_GPIO_E_OE[i], I_GPIO_E_OUT[i]};
            if (de_on && mode == pbm_pkg::PBM_MODE_WAVE) begin
                {pd_oe_d[i], pd_d[i]} = {I_WAVE_DATA_B_OE,
                    I_WAVE_DATA_B_OUT[i]};
            end else if (de_on && mode == pbm_pkg::PBM_MODE_FIFO) begin
                {pd_oe_d[i], pd_d[i]} = {I_FIFO_B_DATA_OE, I_FIFO_B_DATA_OUT[i]};
            end
        end
        for (int i = 0; i <= `PBM_E_ADDR_TOP; i++) begin
            if (de_on && mode == pbm_pkg::PBM_MODE_WAVE) begin
                {pe_oe_d[i], pe_d[i]} = {1'b1, I_WAVE_ADDRESS[i]};
            end
        end
        if (de_on && mode == pbm_pkg::PBM_MODE_FIFO) begin
            pe_oe_d[`PBM_E_ADDR_TOP:0] = 5'h1f;
            pe_d[`PBM_E_ADDR_TOP:0] = {I_FIFO_B_OUT_EMPTY, I_FIFO_A_OUT_EMPTY,
                I_FIFO_B_IN_FULL, I_FIFO_A_IN_FULL,
                I_FIFO_B_OUT_LEVEL_FLAG};
        end
        if (mode == pbm_pkg::PBM_MODE_WAVE) begin
            pe_oe_d[`PBM_E_WAVE_CONTROL_5:`PBM_E_WAVE_CONTROL_3] = 3'h7;
            pe_d[`PBM_E_WAVE_CONTROL_5:`PBM_E_WAVE_CONTROL_3] = {I_WAVE_CONTROL_5,
                I_WAVE_CONTROL_4, I_WAVE_CONTROL_3};
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            pb_q <= `PBM_ZERO_BYTE;
            pb_oe_q <= `PBM_ZERO_BYTE;
            pc_q <= `PBM_ZERO_BYTE;
            pc_oe_q <= `PBM_ZERO_BYTE;
            pd_q <= `PBM_ZERO_BYTE;
            pd_oe_q <= `PBM_ZERO_BYTE;
            pe_q <= `PBM_ZERO_BYTE;
            pe_oe_q <= `PBM_ZERO_BYTE;
            addr5_q <= 1'b0;
        end else begin
            pb_q <= pb_d;
            pb_oe_q <= pb_oe_d;
            pc_q <= pc_d;
            pc_oe_q <= pc_oe_d;
            pd_q <= pd_d;
            pd_oe_q <= pd_oe_d;
            pe_q <= pe_d;
            pe_oe_q <= pe_oe_d;
            addr5_q <= I_WAVE_ADDRESS[`PBM_PORT_W-3];
        end
    end

    assign O_PB_PIN = pb_q;
    assign O_PB_PIN_OE = pb_oe_q;
    assign O_PC_PIN = pc_q;
    assign O_PC_PIN_OE = pc_oe_q;
    assign O_PD_PIN = pd_q;
    assign O_PD_PIN_OE = pd_oe_q;
    assign O_PE_PIN = pe_q;
    assign O_PE_PIN_OE = pe_oe_q;
    assign O_WAVE_ADDRESS_5 = addr5_q;

    // Unrouted peripheral inputs idle.
    assign O_TIMER2_COUNT_INPUT = b_per[`PBM_B_T2IN] & pb_s[`PBM_B_T2IN];
    assign O_TIMER2_RELOAD_INPUT = b_per[`PBM_B_T2EX] & pb_s[`PBM_B_T2EX];
    assign O_UART1_RECEIVE = ~b_per[`PBM_B_RX1] | pb_s[`PBM_B_RX1];
    assign O_UART0_RECEIVE = ~c_per[`PBM_C_RX0] | pc_s[`PBM_C_RX0];
    assign O_TIMER0_COUNT_INPUT = I_TIMER0_COUNTER_MODE & c_per[`PBM_C_T0]
        & pc_s[`PBM_C_T0];
    assign O_TIMER1_COUNT_INPUT = I_TIMER1_COUNTER_MODE & c_per[`PBM_C_T1]
        & pc_s[`PBM_C_T1];
    assign O_WAVE_READY_0 = (c_wav[`PBM_C_RX0] & pc_s[`PBM_C_RX0])
        | ((mode == pbm_pkg::PBM_MODE_WAVE) & ded_s[`PBM_DED_0]);
    assign O_WAVE_READY_1 = (c_wav[`PBM_C_TX0] & pc_s[`PBM_C_TX0])
        | ((mode == pbm_pkg::PBM_MODE_WAVE) & ded_s[`PBM_DED_1]);
    assign O_WAVE_READY_3 = c_wav[`PBM_C_EXT_IRQ_ONE_N] & pc_s[`PBM_C_EXT_IRQ_ONE_N];
    assign O_FIFO_A_SELECT = (mode == pbm_pkg::PBM_MODE_FIFO)
        & ded_s[`PBM_DED_0];
    assign O_FIFO_B_SELECT = (mode == pbm_pkg::PBM_MODE_FIFO)
        & ded_s[`PBM_DED_1];

    assign irq_lvl = {pb_s[`PBM_B_EXT_IRQ_SIX], pb_s[`PBM_B_EXT_IRQ_FIVE_N], pb_s[`PBM_B_EXT_IRQ_FOUR],
        pc_s[`PBM_C_EXT_IRQ_ONE_N], pc_s[`PBM_C_EXT_IRQ_ZERO_N]};
    assign irq_en = {b_per[`PBM_B_EXT_IRQ_SIX], b_per[`PBM_B_EXT_IRQ_FIVE_N],
        b_per[`PBM_B_EXT_IRQ_FOUR], c_per[`PBM_C_EXT_IRQ_ONE_N], c_alt_q[`PBM_C_EXT_IRQ_ZERO_N]};
    assign irq_fall = 5'b01011;
    assign irq_edge = {3'b111, I_IRQ_ONE_TRIGGER_TYPE,
        I_IRQ_ZERO_TRIGGER_TYPE};

    pbm_irq_edge #(.W(`PBM_IRQ_W)) u_irq (
        .i_clk(I_REF_CLK),
        .i_rst(I_RST),
        .i_level(irq_lvl),
        .i_enable(irq_en),
        .i_falling(irq_fall),
        .i_edge_mode(irq_edge),
        .o_req(irq_req)
    );

    assign O_IRQ_ZERO_REQ = irq_req[`PBM_IRQ_ZERO];
    assign O_IRQ_ONE_REQ = irq_req[`PBM_IRQ_ONE];
    assign O_IRQ_FOUR_REQ = irq_req[`PBM_IRQ_FOUR];
    assign O_IRQ_FIVE_REQ = irq_req[`PBM_IRQ_FIVE];
    assign O_IRQ_SIX_REQ = irq_req[`PBM_IRQ_SIX];

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_RST);

    chk_reset_all_inputs: assert property (
        $past(I_RST) |-> (O_PB_PIN_OE == 8'h00 && O_PC_PIN_OE == 8'h00
            && O_PD_PIN_OE == 8'h00 && O_PE_PIN_OE == 8'h00))
        else $error("Pin drives after reset.");
    chk_t2_pulse_high: assert property (
        (b_per[`PBM_B_TIMER2_OVERFLOW_PULSE] && I_TIMER2_OVERFLOW_PULSE)
            |=> (O_PB_PIN[`PBM_B_TIMER2_OVERFLOW_PULSE] && O_PB_PIN_OE[`PBM_B_TIMER2_OVERFLOW_PULSE]))
        else $error("No timer2 pulse.");
    chk_t2_pulse_low: assert property (
        (b_per[`PBM_B_TIMER2_OVERFLOW_PULSE] && !I_TIMER2_OVERFLOW_PULSE)
            |=> !O_PB_PIN[`PBM_B_TIMER2_OVERFLOW_PULSE])
        else $error("Bit 7 high, no overflow.");
    chk_tx1_drive: assert property (
        b_per[`PBM_B_TX1] |=> (O_PB_PIN[`PBM_B_TX1] == $past(I_UART1_TRANSMIT)
            && O_PB_PIN_OE[`PBM_B_TX1]))
        else $error("No UART1 transmit.");
    chk_irq4_rise: assert property (
        (b_per[`PBM_B_EXT_IRQ_FOUR] && $past(b_per[`PBM_B_EXT_IRQ_FOUR])
            && $rose(pb_s[`PBM_B_EXT_IRQ_FOUR])) |=> O_IRQ_FOUR_REQ)
        else $error("No request four.");
    chk_irq5_fall: assert property (
        (b_per[`PBM_B_EXT_IRQ_FIVE_N] && $past(b_per[`PBM_B_EXT_IRQ_FIVE_N])
            && $fell(pb_s[`PBM_B_EXT_IRQ_FIVE_N])) |=> O_IRQ_FIVE_REQ)
        else $error("No request five.");
    chk_irq6_single: assert property (
        O_IRQ_SIX_REQ |=> !O_IRQ_SIX_REQ)
        else $error("Request six too long.");
    chk_irq0_level: assert property (
        (!I_IRQ_ZERO_TRIGGER_TYPE && c_alt_q[`PBM_C_EXT_IRQ_ZERO_N]
            && !pc_s[`PBM_C_EXT_IRQ_ZERO_N]) |=> O_IRQ_ZERO_REQ)
        else $error("No request zero.");
    chk_t0_ignored: assert property (
        !I_TIMER0_COUNTER_MODE |-> !O_TIMER0_COUNT_INPUT)
        else $error("Timer0 pin not gated.");
    chk_fifo_flags_e: assert property (
        (de_on && mode == pbm_pkg::PBM_MODE_FIFO)
            |=> (O_PE_PIN[0] == $past(I_FIFO_B_OUT_LEVEL_FLAG)
            && O_PE_PIN[`PBM_E_ADDR_TOP] == $past(I_FIFO_B_OUT_EMPTY)))
        else $error("Bad FIFO flags.");
endmodule : pbm_port_mux

// file: pbm_pin_model.sv
// Far-side pins: outside driver and pull-up.
// Assumes the device drive wins whenever its enable is high.
`timescale 1ns/1ps
module pbm_pin_model (
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_ext,
    input wire logic i_ext_en,
    output logic [7:0] o_level
);
    // An undriven pin rests high.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i_oe[i]) begin
                o_level[i] = i_out[i];
            end else if (i_ext_en) begin
                o_level[i] = i_ext[i];
            end else begin
                o_level[i] = 1'b1;
            end
        end
    end
endmodule : pbm_pin_model

// file: tb.sv
// Self-checking bench of the port mux.
// Assumes pin models drive the port B to E pin inputs; src drives I_DED_PIN.
`timescale 1ns/1ps
module tb;
    logic I_REF_CLK, I_RST, I_IRQ_ZERO_TRIGGER_TYPE, I_IRQ_ONE_TRIGGER_TYPE;
    logic I_TIMER0_COUNTER_MODE, I_TIMER1_COUNTER_MODE, I_CPU_DATA_OE;
    logic I_WAVE_DATA_A_OE, I_WAVE_DATA_B_OE, I_WAVE_CONTROL_1;
    logic I_WAVE_CONTROL_3, I_WAVE_CONTROL_4, I_WAVE_CONTROL_5;
    logic I_FIFO_A_DATA_OE, I_FIFO_B_DATA_OE, I_FIFO_B_OUT_LEVEL_FLAG;
    logic I_FIFO_A_IN_FULL, I_FIFO_B_IN_FULL, I_FIFO_A_OUT_EMPTY;
    logic I_FIFO_B_OUT_EMPTY, I_UART1_TRANSMIT, I_UART0_TRANSMIT;
    logic I_TIMER2_OVERFLOW_PULSE, I_MEM_WRITE_N, I_MEM_READ_N, ext_en;
    logic [2:0] I_INTERFACE_MODE_FIELD;
    logic [5:0] I_WAVE_ADDRESS;
    logic [1:0] I_DED_PIN;
    logic [7:0] I_PORT_B_ALT_SELECT, I_PORT_C_ALT_SELECT, I_PORT_C_WAVE_SELECT;
    logic [7:0] I_PB_PIN, I_PC_PIN, I_PD_PIN, I_PE_PIN;
    logic [7:0] ext_b, ext_c, ext_d, ext_e;
    logic [7:0] I_GPIO_B_OUT, I_GPIO_B_OE, I_GPIO_C_OUT, I_GPIO_C_OE;
    logic [7:0] I_GPIO_D_OUT, I_GPIO_D_OE, I_GPIO_E_OUT, I_GPIO_E_OE;
    logic [7:0] I_CPU_DATA_OUT, I_WAVE_DATA_A_OUT, I_WAVE_DATA_B_OUT;
    logic [7:0] I_FIFO_A_DATA_OUT, I_FIFO_B_DATA_OUT;
    logic [7:0] O_PB_PIN, O_PB_PIN_OE, O_PC_PIN, O_PC_PIN_OE;
    logic [7:0] O_PD_PIN, O_PD_PIN_OE, O_PE_PIN, O_PE_PIN_OE;
    logic [7:0] O_PORT_B_LEVEL, O_PORT_C_LEVEL, O_PORT_D_LEVEL, O_PORT_E_LEVEL;
    logic O_WAVE_ADDRESS_5, O_WAVE_READY_0, O_WAVE_READY_1, O_WAVE_READY_3;
    logic O_FIFO_A_SELECT, O_FIFO_B_SELECT, O_TIMER2_COUNT_INPUT;
    logic O_TIMER2_RELOAD_INPUT, O_UART1_RECEIVE, O_UART0_RECEIVE;
    logic O_TIMER0_COUNT_INPUT, O_TIMER1_COUNT_INPUT, O_IRQ_ZERO_REQ;
    logic O_IRQ_ONE_REQ, O_IRQ_FOUR_REQ, O_IRQ_FIVE_REQ, O_IRQ_SIX_REQ;
    logic [5:0] ev;
    int failures = 0;
    int n_tests = 0;
    assign ev = {O_PB_PIN[7], O_IRQ_SIX_REQ, O_IRQ_FIVE_REQ, O_IRQ_FOUR_REQ,
        O_IRQ_ONE_REQ, O_IRQ_ZERO_REQ};
    pbm_port_mux uut (.*);
    pbm_pin_model pm_b (.i_out(O_PB_PIN), .i_oe(O_PB_PIN_OE), .i_ext(ext_b),
        .i_ext_en(ext_en), .o_level(I_PB_PIN));
    pbm_pin_model pm_c (.i_out(O_PC_PIN), .i_oe(O_PC_PIN_OE), .i_ext(ext_c),
        .i_ext_en(ext_en), .o_level(I_PC_PIN));
    pbm_pin_model pm_d (.i_out(O_PD_PIN), .i_oe(O_PD_PIN_OE), .i_ext(ext_d),
        .i_ext_en(ext_en), .o_level(I_PD_PIN));
    pbm_pin_model pm_e (.i_out(O_PE_PIN), .i_oe(O_PE_PIN_OE), .i_ext(ext_e),
        .i_ext_en(ext_en), .o_level(I_PE_PIN));
    initial begin
        I_REF_CLK = 1'b0;
        forever #50 I_REF_CLK = ~I_REF_CLK;
    end
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %0t %h %h", $time, g, e);
        end
    endtask : chk
    // Counts high cycles of one event line over six cycles.
    task automatic cnt(input int k, output int c);
        c = 0;
        for (int i = 0; i < 6; i++) begin
            c += int'(ev[k] === 1'b1);
            @(negedge I_REF_CLK);
        end
    endtask : cnt
    task automatic wt(input int n);
        repeat (n) @(negedge I_REF_CLK);
    endtask : wt
    task automatic src();
        {I_GPIO_B_OUT, I_GPIO_B_OE, I_GPIO_C_OUT, I_GPIO_C_OE} = $urandom;
        {I_GPIO_D_OUT, I_GPIO_D_OE, I_GPIO_E_OUT, I_GPIO_E_OE} = $urandom;
        {I_CPU_DATA_OUT, I_WAVE_DATA_A_OUT, I_WAVE_DATA_B_OUT,
            I_FIFO_A_DATA_OUT} = $urandom;
        {I_FIFO_B_DATA_OUT, I_WAVE_ADDRESS, I_DED_PIN, ext_b, ext_d} = $urandom;
        {I_CPU_DATA_OE, I_WAVE_DATA_A_OE, I_WAVE_DATA_B_OE, I_FIFO_A_DATA_OE,
            I_FIFO_B_DATA_OE, I_WAVE_CONTROL_1, I_WAVE_CONTROL_3,
            I_WAVE_CONTROL_4, I_WAVE_CONTROL_5, I_FIFO_B_OUT_LEVEL_FLAG,
            I_FIFO_A_IN_FULL, I_FIFO_B_IN_FULL, I_FIFO_A_OUT_EMPTY,
            I_FIFO_B_OUT_EMPTY, I_UART1_TRANSMIT, I_UART0_TRANSMIT,
            I_MEM_WRITE_N, I_MEM_READ_N, ext_c} = 26'($urandom);
        ext_e = 8'($urandom);
    endtask : src
    function automatic logic [7:0] lvl(logic [7:0] o, logic [7:0] e,
        logic [7:0] x);
        return (o & e) | (x & ~e);
    endfunction : lvl
    initial begin
        #500000;
        failures++;
        test_done();
    end
    initial begin
        int c;
        logic [7:0] d;
        logic o;
        logic [2:0] ml [4] = '{3'h0, 3'h1, 3'h6, 3'h7};
        void'($urandom(62648));
        {I_RST, ext_en, I_TIMER2_OVERFLOW_PULSE} = 3'h4;
        {I_IRQ_ZERO_TRIGGER_TYPE, I_IRQ_ONE_TRIGGER_TYPE} = 2'h3;
        {I_TIMER0_COUNTER_MODE, I_TIMER1_COUNTER_MODE} = 2'h0;
        {I_INTERFACE_MODE_FIELD, I_PORT_B_ALT_SELECT} = 11'h0;
        {I_PORT_C_ALT_SELECT, I_PORT_C_WAVE_SELECT} = 16'h0;
        src();
        {I_GPIO_B_OE, I_GPIO_C_OE, I_GPIO_D_OE, I_GPIO_E_OE} = '0;
        wt(20);
        I_RST = 1'b0;
        wt(3);
        chk({O_PB_PIN_OE, O_PC_PIN_OE, O_PD_PIN_OE, O_PE_PIN_OE}, 0);
        chk(O_PORT_C_LEVEL, 8'hff);
        ext_en = 1'b1;
        for (int i = 0; i < 8; i++) begin
            src();
            wt(4);
            chk({O_PB_PIN_OE, O_PB_PIN & O_PB_PIN_OE},
                {I_GPIO_B_OE, I_GPIO_B_OUT & I_GPIO_B_OE});
            chk(O_PORT_B_LEVEL,
                lvl(I_GPIO_B_OUT, I_GPIO_B_OE, ext_b));
        end
        I_PORT_B_ALT_SELECT = 8'h88;
        for (int j = 0; j < 2; j++) begin
            I_UART1_TRANSMIT = j[0];
            wt(3);
            chk({O_PB_PIN_OE[3], O_PB_PIN[3]}, {1'b1, j[0]});
        end
        I_TIMER2_OVERFLOW_PULSE = 1'b1;
        wt(1);
        I_TIMER2_OVERFLOW_PULSE = 1'b0;
        cnt(5, c);
        chk(c, 1);
        I_PORT_B_ALT_SELECT = 8'hf8;
        ext_b = 8'h00;
        wt(8);
        for (int b = 4; b < 7; b++) begin
            ext_b[b] = 1'b1;
            cnt(b - 2, c);
            chk(c, int'(b != 5));
            ext_b[b] = 1'b0;
            cnt(b - 2, c);
            chk(c, int'(b == 5));
        end
        I_PORT_C_ALT_SELECT = 8'h3c;
        ext_c = 8'h0c;
        wt(8);
        for (int z = 0; z < 2; z++) begin
            ext_c[2 + z] = 1'b0;
            cnt(z, c);
            chk(c, 1);
            ext_c[2 + z] = 1'b1;
            cnt(z, c);
            chk(c, 0);
        end
        {I_IRQ_ZERO_TRIGGER_TYPE, I_IRQ_ONE_TRIGGER_TYPE} = 2'h0;
        ext_c = 8'h30;
        wt(4);
        cnt(0, c);
        chk(c, 6);
        cnt(1, c);
        chk(c, 6);
        for (int j = 0; j < 4; j++) begin
            {I_TIMER1_COUNTER_MODE, I_TIMER0_COUNTER_MODE} = j[1:0];
            wt(4);
            chk({O_TIMER1_COUNT_INPUT, O_TIMER0_COUNT_INPUT}, j[1:0]);
        end
        foreach (ml[k]) begin
            I_INTERFACE_MODE_FIELD = ml[k];
            I_PORT_B_ALT_SELECT = 8'h00;
            I_PORT_C_ALT_SELECT = 8'hf2;
            I_PORT_C_WAVE_SELECT = (ml[k] == 3'h6) ? 8'hf0 : 8'h00;
            for (int i = 0; i < 4; i++) begin
                src();
                wt(4);
                case (ml[k][1:0])
                    2'h1: {d, o} = {I_CPU_DATA_OUT, I_CPU_DATA_OE};
                    2'h2: {d, o} = {I_WAVE_DATA_A_OUT, I_WAVE_DATA_A_OE};
                    default: {d, o} = {I_FIFO_A_DATA_OUT, I_FIFO_A_DATA_OE};
                endcase
                if (ml[k] != 3'h0) begin
                    chk({O_PB_PIN_OE, O_PB_PIN & O_PB_PIN_OE},
                        {{8{o}}, d & {8{o}}});
                end
                chk({O_PC_PIN_OE[7:4], O_PC_PIN[7:6], O_PC_PIN[1],
                    O_PC_PIN_OE[1]},
                    (ml[k] == 3'h6) ? {4'hf, I_WAVE_CONTROL_5, I_WAVE_CONTROL_4,
                    I_UART0_TRANSMIT, 1'b1} : {4'hc, I_MEM_READ_N, I_MEM_WRITE_N,
                    I_UART0_TRANSMIT, 1'b1});
                chk(O_WAVE_ADDRESS_5, I_WAVE_ADDRESS[5]);
                if (ml[k] == 3'h6) begin
                    chk({O_PC_PIN[5:4], O_PE_PIN[7:5], O_PE_PIN_OE[7:5]},
                        {I_WAVE_CONTROL_3, I_WAVE_CONTROL_1, I_WAVE_CONTROL_5,
                        I_WAVE_CONTROL_4, I_WAVE_CONTROL_3, 3'h7});
                    chk({O_PE_PIN_OE[4:0], O_PE_PIN[4:0]},
                        {5'h1f, I_WAVE_ADDRESS[4:0]});
                    chk({O_WAVE_READY_1, O_WAVE_READY_0}, I_DED_PIN);
                    {d, o} = {I_WAVE_DATA_B_OUT, I_WAVE_DATA_B_OE};
                end else if (ml[k] == 3'h7) begin
                    chk({O_PE_PIN_OE[4:0], O_PE_PIN[4:0]}, {5'h1f,
                        I_FIFO_B_OUT_EMPTY, I_FIFO_A_OUT_EMPTY, I_FIFO_B_IN_FULL,
                        I_FIFO_A_IN_FULL, I_FIFO_B_OUT_LEVEL_FLAG});
                    chk({O_FIFO_B_SELECT, O_FIFO_A_SELECT}, I_DED_PIN);
                    {d, o} = {I_FIFO_B_DATA_OUT, I_FIFO_B_DATA_OE};
                end
                if (ml[k][2]) begin
                    chk({O_PD_PIN_OE, O_PD_PIN & O_PD_PIN_OE},
                        {{8{o}}, d & {8{o}}});
                end
            end
        end
        test_done();
    end
endmodule : tb
